// ===== src/line_unit_pkg.sv
// Package with register map, field layout and equalizer decode types for the line unit channel control
package line_unit_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] control_0_offset  = 8'h00;
  localparam logic [7:0] seg_base_offset   = 8'h08;
  localparam logic [7:0] status_offset     = 8'h04;
  localparam int         seg_count         = 8;
  localparam logic [7:0] control_0_reset   = 8'h00;
  localparam logic [7:0] seg_reset         = 8'h00;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int pattern_type_bit  = 7;
  localparam int route_bit         = 6;
  localparam int receiver_on_bit   = 5;
  localparam int eq_msb            = 4;

  // ********************************************************************
  // Equalizer decode types
  // ********************************************************************
  typedef enum logic [1:0] {line_long_haul_type_v, line_short_haul_type_v, line_gain_type_v} haul_type;
  typedef enum logic [1:0] {sens_15db, sens_29db, sens_36db, sens_45db} sensitivity_type;
  typedef enum logic [1:0] {cable_tp100, cable_coax75, cable_tp120} cable_type;

  typedef struct packed {
    logic            e1_mode;
    haul_type        haul;
    sensitivity_type sensitivity;
    cable_type       cable;
    logic            arbitrary;
    logic [2:0]      build_out;   // 0..3 attenuation step or 0..4 cable length step
    logic            length_mode; // Build-out given as cable length
  } eq_setting_type;

  typedef struct packed {
    logic       pattern_type_select;
    logic       generator_output_route;
    logic       receiver_power_on;
    logic [4:0] equalizer_code;
  } control_0_type;

endpackage

// ===== src/line_unit_channel_control.sv
// Wishbone register bank for one line unit channel: control register, equalizer decode and pulse segments
`timescale 1ns/1ps
`default_nettype none

module line_unit_channel_control
  import line_unit_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Pattern generator control
  input  wire logic        pattern_enable,
  output logic             pattern_type_select,
  output logic             pattern_to_line,
  output logic             pattern_to_receive,
  // Receive section power
  output logic             receiver_power_on,
  output logic             receive_power_down,
  // Equalizer setting
  output logic [4:0]       equalizer_code,
  output eq_setting_type   eq_setting,
  // Transmit pulse amplitude
  input  wire logic [2:0]  segment_index,
  output logic [7:0]       pulse_amplitude
);

  // ********************************************************************
  // Behaviour notes
  // ********************************************************************
  // Bus: a request is taken on an edge with cyc and stb high while no
  // answer is pending; ack or err follows one cycle later and stands for
  // one cycle. The master must drop stb after the ack cycle, because a
  // stb still held in the following cycle is taken as a new request.
  // Writes land on the edge that raises ack, so the new control value
  // and every output derived from it except pulse_amplitude, which follows one cycle later, show during the ack cycle.
  // Only byte lane 0 carries write data; a write with that lane off is still
  // acknowledged and leaves the register alone.
  // Unmapped offsets answer with err and change nothing.
  // The status word is read-only; writes to it are acknowledged and dropped.
  // Decoded setting and receive power state are registered from the next
  // control value, so they change on the same edge as the register.
  // Pulse amplitude trails segment_index by one clock and is held at zero
  // unless an arbitrary pulse code is selected.
  // Segment slots follow address bits 4..2, so the window 0x08..0x24
  // wraps: 0x08 is slot 2 and 0x20 is slot 0; software must use that map.
  // segment_index comes from the shaper on this clock and needs no sync.
  // pattern_enable also comes from this clock; the two route outputs are
  // plain gates on it so the generator switches in the same cycle.
  // Receive power down is the inverse of the receiver enable bit; the
  // master clock loop is outside this block and never powered down here.
  // E1 codes leave build_out at zero: the pulse template is fixed.
  // Arbitrary codes report build_out 5, one past the last cable length.

  // ********************************************************************
  // Address, control and status helpers
  // ********************************************************************
  // Segment slot from a word address, taken from address bits 4..2 alone
  function automatic logic [2:0] seg_slot(input logic [7:0] adr);
    return adr[4:2];
  endfunction

  // True for a word-aligned offset inside the segment window
  function automatic logic seg_window(input logic [7:0] adr);
    logic above_base;
    logic below_top;
    above_base = (adr >= seg_base_offset);
    below_top  = (adr < 8'(seg_base_offset + 8'(4 * seg_count)));
    return above_base && below_top && (adr[1:0] == 2'b00);
  endfunction

  // Control byte to fields
  function automatic control_0_type unpack_control(input logic [7:0] d);
    control_0_type c;
    c                        = '0;
    c.pattern_type_select    = d[pattern_type_bit];
    c.generator_output_route = d[route_bit];
    c.receiver_power_on      = d[receiver_on_bit];
    c.equalizer_code         = d[eq_msb:0];
    return c;
  endfunction

  // Fields back to the control byte for reads
  function automatic logic [7:0] pack_control(input control_0_type c);
    logic [7:0] d;
    d                   = 8'h00;
    d[pattern_type_bit] = c.pattern_type_select;
    d[route_bit]        = c.generator_output_route;
    d[receiver_on_bit]  = c.receiver_power_on;
    d[eq_msb:0]         = c.equalizer_code;
    return d;
  endfunction

  // Read-only status word: decoded equalizer setting and receive power state
  function automatic logic [31:0] pack_status(input eq_setting_type s, input logic down);
    logic [31:0] w;
    w       = 32'h0000_0000;
    w[0]    = down;              // Receive section powered down
    w[3:2]  = 2'(s.cable);       // Cable type
    w[5:4]  = 2'(s.sensitivity); // Receive sensitivity
    w[7:6]  = 2'(s.haul);        // Line mode
    w[10:8] = s.build_out;       // Build-out step
    w[11]   = s.arbitrary;       // Arbitrary pulse shaping
    w[12]   = s.e1_mode;         // E1 operation
    return w;
  endfunction

  // ********************************************************************
  // Equalizer decode
  // ********************************************************************
  function automatic eq_setting_type decode_eq(input logic [4:0] code);
    eq_setting_type s;
    s = '0;
    s.cable = cable_tp100;
    s.haul = line_long_haul_type_v;
    s.sensitivity = sens_36db;
    if (code <= 5'h07) begin
      // Long haul: bit 2 picks 45 dB, bits 1..0 step the attenuation
      s.sensitivity = code[2] ? sens_45db : sens_36db;
      s.build_out = {1'b0, code[1:0]};
    end else if (code <= 5'h0D) begin
      // Short haul: cable length steps, last code is arbitrary
      s.haul = line_short_haul_type_v;
      s.sensitivity = sens_15db;
      s.arbitrary = (code == 5'h0D);
      s.length_mode = 1'b1;
      s.build_out = 3'(code - 5'h08);
    end else if (code <= 5'h13) begin
      // Gain mode with cable length steps, last code is arbitrary
      s.haul = line_gain_type_v;
      s.sensitivity = sens_29db;
      s.arbitrary = (code == 5'h13);
      s.length_mode = 1'b1;
      s.build_out = 3'(code - 5'h0E);
    end else if (code <= 5'h17) begin
      // Gain mode with attenuation steps
      s.haul = line_gain_type_v;
      s.sensitivity = sens_29db;
      s.build_out = {1'b0, code[1:0]};
    end else begin
      // E1: pairs of codes, bit 0 picks the cable
      s.e1_mode = 1'b1;
      s.cable = code[0] ? cable_tp120 : cable_coax75;
      unique case (code[2:1])
        2'd0: begin
          s.sensitivity = sens_36db;
        end
        2'd1: begin
          s.sensitivity = sens_45db;
        end
        2'd2: begin
          s.haul = line_short_haul_type_v;
          s.sensitivity = sens_15db;
        end
        2'd3: begin
          s.haul = line_gain_type_v;
          s.sensitivity = sens_29db;
        end
      endcase
    end
    return s;
  endfunction

  // ********************************************************************
  // Register state
  // ********************************************************************
  control_0_type control_0;
  control_0_type next_control_0;
  logic [7:0]    seg [seg_count];
  logic [7:0]    next_seg [seg_count];
  logic          next_ack;
  logic          next_err;
  logic [31:0]   next_dat;
  eq_setting_type next_eq_setting;
  logic          next_power_down;
  logic [7:0]    next_pulse_amplitude;

  // ********************************************************************
  // Request decode
  // ********************************************************************

  logic req;
  logic is_ctrl;
  logic is_status;
  logic is_seg;
  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign is_ctrl   = (wb_adr_i == control_0_offset);
  assign is_status = (wb_adr_i == status_offset);
  assign is_seg    = seg_window(wb_adr_i);

  // ********************************************************************
  // Read and write path
  // ********************************************************************
  // Next register values, write takes effect on the acknowledging edge
  always_comb begin
    next_control_0 = control_0;
    for (int i = 0; i < seg_count; i++) begin
      next_seg[i] = seg[i];
    end
    next_ack = 1'b0;
    next_err = 1'b0;
    next_dat = wb_dat_o;
    if (req) begin
      next_ack = is_ctrl || is_status || is_seg;
      next_err = !(is_ctrl || is_status || is_seg);
      next_dat = 32'h0000_0000;
      if (is_ctrl) begin
        next_dat = {24'h00_0000, pack_control(control_0)};
        if (wb_we_i && wb_sel_i[0]) begin
          next_control_0 = unpack_control(wb_dat_i[7:0]);
        end
      end else if (is_status) begin
        next_dat = pack_status(eq_setting, receive_power_down);
      end else if (is_seg) begin
        next_dat = {24'h00_0000, seg[seg_slot(wb_adr_i)]};
        if (wb_we_i && wb_sel_i[0]) begin
          next_seg[seg_slot(wb_adr_i)] = wb_dat_i[7:0];
        end
      end
    end
    // Decoded setting and power state follow the next control value
    next_eq_setting = decode_eq(next_control_0.equalizer_code);
    next_power_down = !next_control_0.receiver_power_on;
  end

  // Register update with synchronous reset: zero, except decoded setting and power down, taken from the reset control value
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      control_0 <= control_0_reset;
      for (int i = 0; i < seg_count; i++) begin
        seg[i] <= seg_reset;
      end
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      eq_setting <= decode_eq(control_0_reset[4:0]);
      receive_power_down <= !control_0_reset[receiver_on_bit];
    end else begin
      control_0 <= next_control_0;
      for (int i = 0; i < seg_count; i++) begin
        seg[i] <= next_seg[i];
      end
      wb_ack_o <= next_ack;
      wb_err_o <= next_err;
      wb_dat_o <= next_dat;
      eq_setting <= next_eq_setting;
      receive_power_down <= next_power_down;
    end
  end

  // ********************************************************************
  // Outputs steered by the control register
  // ********************************************************************
  assign pattern_type_select = control_0.pattern_type_select;
  assign pattern_to_line     = pattern_enable && !control_0.generator_output_route;
  assign pattern_to_receive  = pattern_enable && control_0.generator_output_route;
  assign receiver_power_on   = control_0.receiver_power_on;
  assign equalizer_code      = control_0.equalizer_code;

  // ********************************************************************
  // Pulse amplitude
  // ********************************************************************
  // Segment amplitude drives the pulse only in arbitrary mode
  always_comb begin
    next_pulse_amplitude = eq_setting.arbitrary ? seg[segment_index] : 8'h00;
  end

  // Pulse amplitude register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pulse_amplitude <= 8'h00;
    end else begin
      pulse_amplitude <= next_pulse_amplitude;
    end
  end

endmodule

`default_nettype wire

// ===== testbench/line_unit_channel_control_checker.sv
// Checker for the line unit channel control bank
`timescale 1ns/1ps
`default_nettype none
module line_unit_channel_control_checker
  import line_unit_pkg::*;
(
  // Watched ports
  input wire logic        clk_sys, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
  input wire logic [7:0]  wb_adr_i, pulse_amplitude,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        pattern_enable, pattern_type_select, pattern_to_line, pattern_to_receive,
  input wire logic        receiver_power_on, receive_power_down,
  input wire logic [4:0]  equalizer_code,
  input wire eq_setting_type eq_setting
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire [4:0] c = equalizer_code;
  // ****************
  // Bus and register
  // ****************
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=>
    (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o | wb_err_o)) else $error("bus answer");
  a_write_lands: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] |->
    c == wb_dat_i[4:0] && pattern_type_select == wb_dat_i[7] && receiver_power_on == wb_dat_i[5])
    else $error("write lost");
  a_reset_zero: assert property ($past(srst) |-> c == 5'h00 && !pattern_type_select && !receiver_power_on)
    else $error("reset value");
  a_route_split: assert property ((pattern_to_line | pattern_to_receive) == pattern_enable
    && !(pattern_to_line && pattern_to_receive)) else $error("route");
  a_power_pair: assert property (receive_power_down == !receiver_power_on) else $error("power");
  // ****************
  // Equalizer decode
  // ****************
  a_long_haul: assert property (c < 5'h08 |-> eq_setting.haul == line_long_haul_type_v &&
    eq_setting.sensitivity == (c[2] ? sens_45db : sens_36db) && eq_setting.build_out == c[1:0])
    else $error("long haul");
  a_short_haul: assert property (c inside {[5'h08:5'h0C]} |-> eq_setting.sensitivity == sens_15db
    && eq_setting.build_out == c - 5'h08 && eq_setting.length_mode) else $error("short haul");
  a_gain_mode: assert property (c inside {[5'h0E:5'h17]} |-> eq_setting.haul == line_gain_type_v
    && eq_setting.sensitivity == sens_29db) else $error("gain mode");
  a_e1_cable: assert property (c[4:3] == 2'h3 |-> eq_setting.e1_mode &&
    eq_setting.cable == (c[0] ? cable_tp120 : cable_coax75)) else $error("e1 cable");
  a_pulse_off: assert property (!$past(eq_setting.arbitrary) |-> pulse_amplitude == 8'h00)
    else $error("pulse not zero");
endmodule
bind line_unit_channel_control line_unit_channel_control_checker i_line_unit_channel_control_checker (.*);
`default_nettype wire

// ===== testbench/line_model.sv
// Line side model: walks the pulse segments and asks for pattern generation
`timescale 1ns/1ps
`default_nettype none
module line_model (
  // Clock and request
  input  wire logic  clk_sys,
  input  wire logic  gen_on,
  // Towards the block
  output logic       pattern_enable = 1'b0,
  output logic [2:0] segment_index = 3'h0
);
  // Shaper steps one segment a cycle
  always @(posedge clk_sys) begin
    segment_index <= segment_index + 3'h1;
    pattern_enable <= gen_on;
  end
endmodule
`default_nettype wire

// ===== testbench/tb_line_unit_channel_control.sv
// Bench for the line unit channel control bank
`timescale 1ns/1ps
`default_nettype none
module tb_line_unit_channel_control
  import line_unit_pkg::*;
;
  logic        clk_sys = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, gen_on = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, pulse_amplitude, segs [8];
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, wb_err_o, pattern_enable, pattern_type_select, pattern_to_line, pattern_to_receive;
  logic        receiver_power_on, receive_power_down, e;
  logic [4:0]  equalizer_code;
  logic [2:0]  segment_index, prev;
  eq_setting_type eq_setting;
  int          fail_count = 0, num_checks = 0;
  line_unit_channel_control i_line_unit_channel_control (.*);
  line_model i_line_model (.*);
  always #25 clk_sys = ~clk_sys;
  // Compare and count
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  // One classic Wishbone cycle, held until ack or err is sampled high at a rising edge
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'h1);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(wb_ack_o || wb_err_o) && n < 20);
    rd = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (!(wb_ack_o || wb_err_o)) begin
      fail_count++;
      summarize;
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    repeat (4000) @(posedge clk_sys);
    fail_count++;
    summarize;
  end
  // Test sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    xfer(0, 8'h00, 0);
    chk("control reset", rd, 32'h0);
    chk("power down", receive_power_down, 1);
    gen_on <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      xfer(1, 8'h00, {i[2:0], i[4:0]});
      xfer(0, 8'h00, 0);
      chk("control", rd, {i[2:0], i[4:0]});
      chk("pattern type", pattern_type_select, i[2]);
      chk("route line", pattern_to_line, !i[1]);
      chk("route receive", pattern_to_receive, i[1]);
      chk("receiver on", receiver_power_on, i[0]);
      chk("arbitrary", eq_setting.arbitrary, i == 13 || i == 19);
      chk("e1 mode", eq_setting.e1_mode, i > 23);
    end
    xfer(1, 8'h00, 0, 4'h0);
    xfer(0, 8'h00, 0);
    chk("masked write", rd, 32'hFF);
    xfer(1, 8'h30, 0);
    chk("unmapped", e, 1);
    xfer(1, 8'h00, 32'h26);
    xfer(0, 8'h04, 0);
    chk("status long haul", rd, 32'h230);
    xfer(1, 8'h00, 32'h1D);
    xfer(0, 8'h04, 0);
    chk("status e1", rd, 32'h1049);
    xfer(1, 8'h00, 32'h0D);
    for (int k = 0; k < 8; k++) begin
      segs[(k + 2) % 8] = 8'(8'hA0 + k);
      xfer(1, 8'(8'h08 + 4 * k), 8'hA0 + k);
    end
    @(negedge clk_sys);
    repeat (8) begin
      prev = segment_index;
      @(negedge clk_sys);
      chk("pulse", pulse_amplitude, segs[prev]);
    end
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    xfer(0, 8'h00, 0);
    chk("control after reset", rd, 32'h0);
    summarize;
  end
endmodule
`default_nettype wire
